// >>> core/rmt_mode_ctrl.sv
// Radio operating-mode sequencer with receive timeouts behind AXI4-Lite
// How it works
// - Timeout interrupt if RSSI flag late
// - Timeout interrupt if preamble flag late
// - Timeout interrupt if sync flag late
// - Trigger code selects which timeouts run
// - Three-bit mode code selects six modes
// - Each mode enables only its blocks
// - Blocks wake in fixed order
// - Synthesiser startup always calibrates the VCO
// - FSK transmit startup: 5us, ramp, half bit
// - OOK transmit startup: 5us plus half bit
// - Receive startup set by active bandwidth
// - Receiver ready after receive startup time
// - First RSSI sample one eval interval later
// - Eval interval from bandwidth and smoothing
// - Bit period from bitrate high, low bytes
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module rmt_mode_ctrl import rmt_pkg::*; #(
  parameter int OSC_CYC = OSC_STARTUP_US * CYC_PER_US,
  parameter int US_CYC = CYC_PER_US
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [7:0] signal_strength_value_i,
  input wire logic preamble_seen_flag_i,
  input wire logic sync_word_flag_i,
  output logic xtal_reg_en_o,
  output logic synth_en_o,
  output logic synth_rx_offset_o,
  output logic vco_cal_o,
  output logic tx_en_o,
  output logic rx_en_o,
  output logic mode_ready_o,
  output logic rx_ready_o,
  output logic rssi_valid_o,
  output logic rssi_flag_o,
  output logic irq_o
);
  typedef struct packed {
    logic [31:0] mode_r;
    logic [31:0] rxcfg_r;
    logic [31:0] tout_r;
    logic [31:0] br_r;
    logic [31:0] ramp_r;
    logic [2:0] irq_st;
    logic [2:0] irq_mask;
    rmt_seq_e st;
    logic [2:0] goal;
    logic osc_up;
    logic syn_up;
    logic syn_rx;
    logic [19:0] wcnt;
    logic rx_rdy;
    logic rssi_ok;
    logic rflag_q;
    logic [19:0] ecnt;
    logic [15:0] bcnt;
    logic [3:0] bits16;
    logic [7:0] units;
    logic [2:0] pend;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } rmt_state_s;

  rmt_state_s s;
  rmt_state_s n;
  logic [2:0] goal_in;
  logic [2:0] tvec;
  logic [2:0] fire;
  logic [2:0] seen;
  logic [2:0] w1c;
  logic unit_tick;
  logic advance;
  logic [15:0] bitc;
  logic [4:0] bw;

  // Byte-lane merge of a register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb, input logic [31:0] m);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r & m;
  endfunction

  // Receive startup time in us per bandwidth step
  function automatic logic [11:0] rx_us(input logic [4:0] idx);
    unique case (idx)
      5'd0: return 12'd2330;
      5'd1: return 12'd1940;
      5'd2: return 12'd1560;
      5'd3: return 12'd1180;
      5'd4: return 12'd984;
      5'd5: return 12'd791;
      5'd6: return 12'd601;
      5'd7: return 12'd504;
      5'd8: return 12'd407;
      5'd9: return 12'd313;
      5'd10: return 12'd264;
      5'd11: return 12'd215;
      5'd12: return 12'd169;
      5'd13: return 12'd144;
      5'd14: return 12'd119;
      5'd15: return 12'd97;
      5'd16: return 12'd84;
      5'd17: return 12'd71;
      5'd18: return 12'd85;
      5'd19: return 12'd74;
      default: return 12'd63;
    endcase
  endfunction

  // Mode codes above receive act as standby
  function automatic logic [2:0] legal(input logic [2:0] m);
    return (m > MODE_RX) ? MODE_STDBY : m;
  endfunction

  function automatic logic is_rx(input logic [2:0] m);
    return (m == MODE_SYNTH_TO_RECEIVE) || (m == MODE_RX);
  endfunction

  // Next wake step for a goal mode
  function automatic rmt_seq_e plan(input logic [2:0] g, input logic ou, input logic su, input logic sr);
    if (g == MODE_SLEEP) begin
      return SQ_OFF;
    end else if (!ou) begin
      return SQ_OSC;
    end else if (g >= MODE_SYNTH_TO_TRANSMIT && (!su || sr != is_rx(g))) begin
      return SQ_SYN;
    end else if (g == MODE_TX || g == MODE_RX) begin
      return SQ_TRX;
    end
    return SQ_RDY;
  endfunction

  // Cycles to wait in a wake step, less one
  function automatic logic [19:0] wait_of(input rmt_seq_e q, input logic [2:0] g, input rmt_state_s c,
                                          input logic [15:0] bc, input logic [4:0] b);
    int t;
    t = 1;
    if (q == SQ_OSC) begin
      t = OSC_CYC;
    end else if (q == SQ_SYN) begin
      t = SYN_CYC;
    end else if (q == SQ_TRX && g == MODE_TX) begin
      t = TX_FIXED_CYC + int'(bc) / 2;
      if (!c.mode_r[OOK_BIT]) begin
        t = t + int'(c.ramp_r[7:0]) * US_CYC * RAMP_NUM / RAMP_DEN;
      end
    end else if (q == SQ_TRX) begin
      t = int'(rx_us(b)) * US_CYC;
    end
    if (t < 1) begin
      t = 1;
    end
    return 20'(t - 1);
  endfunction

  // Combinational next state
  always_comb begin
    n = s;
    w1c = '0;
    fire = '0;
    unit_tick = 1'b0;
    advance = 1'b0;
    bitc = (s.br_r[15:0] == '0) ? 16'h0001 : s.br_r[15:0];
    bw = s.rxcfg_r[AFC_BIT] ? s.rxcfg_r[CORRECTION_BANDWIDTH_LSB +: 5] : s.rxcfg_r[RECEIVE_BANDWIDTH_LSB +: 5];
    goal_in = legal(s.mode_r[2:0]);
    unique case (s.rxcfg_r[2:0])
      TRIG_RSSI: tvec = 3'b001;
      TRIG_PRE_SYNC: tvec = 3'b110;
      TRIG_RSSI_PRE: tvec = 3'b011;
      default: tvec = 3'b000;
    endcase
    // AXI write channels and register update
    if (s.bvalid && s_axi_bready_i) begin
      n.bvalid = 1'b0;
    end
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      n.aw_got = 1'b1;
      n.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      n.w_got = 1'b1;
      n.w_data = s_axi_wdata_i;
      n.w_strb = s_axi_wstrb_i;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      unique case ({s.aw_addr[7:2], 2'b00})
        A_MODE: n.mode_r = merge(s.mode_r, s.w_data, s.w_strb, M_MODE);
        A_RXCFG: n.rxcfg_r = merge(s.rxcfg_r, s.w_data, s.w_strb, M_RXCFG);
        A_TOUT: n.tout_r = merge(s.tout_r, s.w_data, s.w_strb, M_TOUT);
        A_BITRATE: n.br_r = merge(s.br_r, s.w_data, s.w_strb, M_BITRATE);
        A_RAMP: n.ramp_r = merge(s.ramp_r, s.w_data, s.w_strb, M_RAMP);
        A_STAT: n.bresp = RESP_OKAY;
        A_IRQ: w1c = s.w_strb[0] ? s.w_data[2:0] : 3'h0;
        A_MASK: n.irq_mask = s.w_strb[0] ? s.w_data[2:0] : s.irq_mask;
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    // AXI read channel
    if (s.rvalid && s_axi_rready_i) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      unique case ({s_axi_araddr_i[7:2], 2'b00})
        A_MODE: n.rdata = s.mode_r;
        A_RXCFG: n.rdata = s.rxcfg_r;
        A_TOUT: n.rdata = s.tout_r;
        A_BITRATE: n.rdata = s.br_r;
        A_RAMP: n.rdata = s.ramp_r;
        A_STAT: n.rdata = {26'h0, s.rssi_ok, s.rx_rdy, s.st == SQ_RDY, s.goal};
        A_IRQ: n.rdata = {29'h0, s.irq_st};
        A_MASK: n.rdata = {29'h0, s.irq_mask};
        default: begin
          n.rdata = 32'h0;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end
    // Wake sequencer: oscillator, synthesiser, then transmitter or receiver
    if (goal_in != s.goal) begin
      n.goal = goal_in;
      if (goal_in == MODE_SLEEP) begin
        n.osc_up = 1'b0;
      end
      if (goal_in <= MODE_STDBY) begin
        n.syn_up = 1'b0;
      end
      n.st = plan(goal_in, n.osc_up, n.syn_up, s.syn_rx);
      n.wcnt = wait_of(n.st, goal_in, s, bitc, bw);
    end else if (s.st == SQ_OSC || s.st == SQ_SYN || s.st == SQ_TRX) begin
      if (s.wcnt == '0) begin
        advance = 1'b1;
      end else begin
        n.wcnt = s.wcnt - 20'h1;
      end
    end
    if (advance) begin
      if (s.st == SQ_OSC) begin
        n.osc_up = 1'b1;
      end
      if (s.st == SQ_SYN) begin
        n.syn_up = 1'b1;
        n.syn_rx = is_rx(s.goal);
      end
      n.st = (s.st == SQ_TRX) ? SQ_RDY : plan(s.goal, n.osc_up, n.syn_up, n.syn_rx);
      n.wcnt = wait_of(n.st, s.goal, s, bitc, bw);
    end
    // Receiver ready and first RSSI sample
    n.rx_rdy = (s.st == SQ_RDY) && (s.goal == MODE_RX) && (goal_in == MODE_RX);
    if (!s.rx_rdy) begin
      n.rssi_ok = 1'b0;
      n.ecnt = 20'(((int'(rx_us(bw)) >> 3) << s.rxcfg_r[SMOOTH_LSB +: 2]) * US_CYC);
    end else if (s.ecnt > 20'h1) begin
      n.ecnt = s.ecnt - 20'h1;
    end else begin
      n.rssi_ok = 1'b1;
    end
    n.rflag_q = rssi_flag_o;
    // Timeouts counted in units of sixteen bit periods from receive entry
    seen = {sync_word_flag_i, preamble_seen_flag_i, rssi_flag_o};
    if (s.goal != MODE_RX) begin
      n.pend = '0;
      n.bcnt = '0;
      n.bits16 = '0;
      n.units = '0;
    end else if (s.bcnt == bitc - 16'h1) begin
      n.bcnt = '0;
      n.bits16 = s.bits16 + 4'h1;
      unit_tick = (s.bits16 == BITS_PER_UNIT_M1);
    end else begin
      n.bcnt = s.bcnt + 16'h1;
    end
    if (unit_tick) begin
      n.units = s.units + 8'h1;
      fire[0] = s.pend[0] && ({1'b0, s.units} + 9'h1 == {1'b0, s.tout_r[7:0]});
      fire[1] = s.pend[1] && ({1'b0, s.units} + 9'h1 == {1'b0, s.tout_r[TO_PRE_LSB +: 8]});
      fire[2] = s.pend[2] && ({1'b0, s.units} + 9'h1 == {1'b0, s.tout_r[TO_SYNC_LSB +: 8]});
    end
    fire = fire & ~seen;
    if (s.goal == MODE_RX) begin
      n.pend = s.pend & ~seen & ~fire;
    end
    if (goal_in == MODE_RX && s.goal != MODE_RX) begin
      n.pend = tvec & {s.tout_r[TO_SYNC_LSB +: 8] != '0, s.tout_r[TO_PRE_LSB +: 8] != '0,
                       s.tout_r[7:0] != '0};
    end
    // Sticky events; a new event beats a clear in the same cycle
    n.irq_st = s.irq_st & ~w1c;
    n.irq_st[IRQ_TIMEOUT] = n.irq_st[IRQ_TIMEOUT] | (|fire);
    n.irq_st[IRQ_READY] = n.irq_st[IRQ_READY] | (n.st == SQ_RDY && s.st != SQ_RDY);
    n.irq_st[IRQ_RSSI] = n.irq_st[IRQ_RSSI] | (rssi_flag_o && !s.rflag_q);
  end

  // State register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s <= '0;
      s.mode_r <= RST_MODE;
      s.rxcfg_r <= RST_RXCFG;
      s.tout_r <= RST_TOUT;
      s.br_r <= RST_BITRATE;
      s.ramp_r <= RST_RAMP;
    end else begin
      s <= n;
    end
  end

  // Bus handshakes and block enables per mode
  assign s_axi_awready_o = !s.aw_got && !s.bvalid;
  assign s_axi_wready_o = !s.w_got && !s.bvalid;
  assign s_axi_bvalid_o = s.bvalid;
  assign s_axi_bresp_o = s.bresp;
  assign s_axi_arready_o = !s.rvalid;
  assign s_axi_rvalid_o = s.rvalid;
  assign s_axi_rdata_o = s.rdata;
  assign s_axi_rresp_o = s.rresp;
  assign xtal_reg_en_o = (s.goal != MODE_SLEEP);
  assign synth_en_o = (s.goal >= MODE_SYNTH_TO_TRANSMIT) && (s.st == SQ_SYN || s.syn_up);
  assign synth_rx_offset_o = is_rx(s.goal);
  assign vco_cal_o = (s.st == SQ_SYN);
  assign tx_en_o = (s.goal == MODE_TX) && (s.st == SQ_TRX || s.st == SQ_RDY);
  assign rx_en_o = (s.goal == MODE_RX) && (s.st == SQ_TRX || s.st == SQ_RDY);
  assign mode_ready_o = (s.st == SQ_RDY);
  assign rx_ready_o = s.rx_rdy;
  assign rssi_valid_o = s.rssi_ok;
  assign rssi_flag_o = s.rssi_ok && (signal_strength_value_i > s.rxcfg_r[THR_LSB +: 8]);
  assign irq_o = |(s.irq_st & s.irq_mask);

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_synth_done;
    vco_cal_o ##1 !vco_cal_o;
  endsequence
  property p_sleep_dark;
    (s.goal == MODE_SLEEP) |-> !xtal_reg_en_o && !synth_en_o && !tx_en_o && !rx_en_o;
  endproperty
  a_sleep_dark: assert property (p_sleep_dark) else $error("Block enabled in sleep");
  property p_rx_mode;
    (mode_ready_o && s.goal == MODE_RX) |-> rx_en_o && !tx_en_o && synth_rx_offset_o;
  endproperty
  a_rx_mode: assert property (p_rx_mode) else $error("Receive mode enables wrong blocks");
  property p_order;
    (s.st == SQ_SYN || s.st == SQ_TRX) |-> s.osc_up;
  endproperty
  a_order: assert property (p_order) else $error("Synthesiser woke before oscillator");
  property p_vco;
    s_synth_done |-> s.syn_up || s.goal != $past(s.goal);
  endproperty
  a_vco: assert property (p_vco) else $error("Calibration ended without lock");
  property p_trig;
    $rose(s.pend[0]) |-> s.rxcfg_r[2:0] == TRIG_RSSI || s.rxcfg_r[2:0] == TRIG_RSSI_PRE;
  endproperty
  a_trig: assert property (p_trig) else $error("RSSI timeout armed by wrong trigger");
  property p_fire;
    (s.pend[0] && unit_tick && s.units + 8'h1 == s.tout_r[7:0] && !seen[0]) |=> s.irq_st[IRQ_TIMEOUT];
  endproperty
  a_fire: assert property (p_fire) else $error("RSSI timeout did not raise interrupt");
  property p_stop;
    (s.pend[1] && preamble_seen_flag_i) |=> !s.pend[1] ##1 !s.pend[1];
  endproperty
  a_stop: assert property (p_stop) else $error("Preamble timeout kept running");
  property p_rssi_first;
    $rose(rssi_valid_o) |-> rx_ready_o && $past(rx_ready_o);
  endproperty
  a_rssi_first: assert property (p_rssi_first) else $error("RSSI sample before receiver ready");
endmodule

// >>> core/rmt_pkg.sv
// Constants and types for the radio mode and receive-timeout controller
package rmt_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int CYC_PER_US = 1000 / CLK_PERIOD_NS;
  localparam int OSC_STARTUP_US = 250;
  localparam int SYN_STARTUP_US = 60;
  localparam int SYN_CYC = SYN_STARTUP_US * CYC_PER_US;
  localparam int TX_FIXED_NS = 5000;
  localparam int TX_FIXED_CYC = (TX_FIXED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAMP_NUM = 5;
  localparam int RAMP_DEN = 4;
  localparam logic [3:0] BITS_PER_UNIT_M1 = 4'hf;
  // Register byte addresses
  localparam logic [7:0] A_MODE = 8'h00;
  localparam logic [7:0] A_RXCFG = 8'h04;
  localparam logic [7:0] A_TOUT = 8'h08;
  localparam logic [7:0] A_BITRATE = 8'h0c;
  localparam logic [7:0] A_RAMP = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [7:0] A_IRQ = 8'h18;
  localparam logic [7:0] A_MASK = 8'h1c;
  // Writable bits and reset values
  localparam logic [31:0] M_MODE = 32'h0000_000f;
  localparam logic [31:0] M_RXCFG = 32'h00ff_ffff;
  localparam logic [31:0] M_TOUT = 32'h00ff_ffff;
  localparam logic [31:0] M_BITRATE = 32'h0000_ffff;
  localparam logic [31:0] M_RAMP = 32'h0000_00ff;
  localparam logic [31:0] RST_MODE = 32'h0000_0001;
  localparam logic [31:0] RST_RXCFG = 32'h0000_0000;
  localparam logic [31:0] RST_TOUT = 32'h0000_0000;
  localparam logic [31:0] RST_BITRATE = 32'h0000_0a00;
  localparam logic [31:0] RST_RAMP = 32'h0000_0028;
  // Field positions
  localparam int OOK_BIT = 3;
  localparam int AFC_BIT = 3;
  localparam int RECEIVE_BANDWIDTH_LSB = 4;
  localparam int CORRECTION_BANDWIDTH_LSB = 9;
  localparam int SMOOTH_LSB = 14;
  localparam int THR_LSB = 16;
  localparam int TO_PRE_LSB = 8;
  localparam int TO_SYNC_LSB = 16;
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_READY = 1;
  localparam int IRQ_RSSI = 2;
  // Operating modes and trigger codes
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STDBY = 3'h1;
  localparam logic [2:0] MODE_SYNTH_TO_TRANSMIT = 3'h2;
  localparam logic [2:0] MODE_TX = 3'h3;
  localparam logic [2:0] MODE_SYNTH_TO_RECEIVE = 3'h4;
  localparam logic [2:0] MODE_RX = 3'h5;
  localparam logic [2:0] TRIG_RSSI = 3'h1;
  localparam logic [2:0] TRIG_PRE_SYNC = 3'h6;
  localparam logic [2:0] TRIG_RSSI_PRE = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {SQ_OFF, SQ_OSC, SQ_SYN, SQ_TRX, SQ_RDY} rmt_seq_e;
endpackage

// >>> verification/rmt_radio_model.sv
// Radio front-end stand-in: strength level and detector flags
`timescale 1ns/1ps
module rmt_radio_model (
  input wire logic clk_sys_i,
  input wire logic rx_ready_i,
  input wire logic [7:0] level_i,
  input wire logic [15:0] pre_dly_i,
  input wire logic [15:0] sync_dly_i,
  output logic [7:0] signal_strength_value_o = 8'h00,
  output logic preamble_seen_flag_o = 1'b0,
  output logic sync_word_flag_o = 1'b0
);
  int cnt = 0;
  logic [7:0] noise = 8'h00;

  // Detectors fire only a set time after the receiver is up; noise otherwise
  always @(posedge clk_sys_i) begin
    cnt <= rx_ready_i ? cnt + 1 : 0;
    noise <= noise + 8'h07;
    preamble_seen_flag_o <= rx_ready_i && pre_dly_i != 0 && cnt == int'(pre_dly_i);
    sync_word_flag_o <= rx_ready_i && sync_dly_i != 0 && cnt == int'(sync_dly_i);
    signal_strength_value_o <= rx_ready_i ? level_i : noise;
  end
endmodule

// >>> verification/radio_mode_and_rx_timeout_tb.sv
// Self-checking bench for the mode sequencer and receive timeouts
`timescale 1ns/1ps
module radio_mode_and_rx_timeout_tb import rmt_pkg::*;;
  logic clk_sys_i = 0;
  logic rst_i = 1;
  logic [7:0] awaddr = 0, araddr = 0, level = 0, strength;
  logic [31:0] wdata = 0, rdata, rd;
  logic [3:0] wstrb = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, pre_flag, sync_flag;
  logic [1:0] bresp, rresp, rsp;
  logic xtal, synth, rx_off, vco_cal, tx_en, rx_en, mode_ready, rx_ready, rssi_valid, rssi_flag, irq;
  logic [15:0] pre_dly = 0, sync_dly = 0;
  logic [2:0] trg [5] = '{3'h0, TRIG_RSSI, TRIG_PRE_SYNC, TRIG_RSSI_PRE, TRIG_RSSI};
  // Timeout fields per case; fields that should stay unarmed would expire first
  logic [23:0] tmul [5] = '{24'h010101, 24'h010102, 24'h020001, 24'h010200, 24'h010100};
  int emul [5] = '{1, 2, 2, 2, 1};
  int errors = 0, samples_checked = 0;
  int n, e, br, to, ramp;

  always #20 clk_sys_i = ~clk_sys_i;

  rmt_mode_ctrl #(.OSC_CYC(20), .US_CYC(1)) i_rmt_mode_ctrl (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .signal_strength_value_i(strength), .preamble_seen_flag_i(pre_flag),
    .sync_word_flag_i(sync_flag), .xtal_reg_en_o(xtal), .synth_en_o(synth), .synth_rx_offset_o(rx_off),
    .vco_cal_o(vco_cal), .tx_en_o(tx_en), .rx_en_o(rx_en), .mode_ready_o(mode_ready), .rx_ready_o(rx_ready),
    .rssi_valid_o(rssi_valid), .rssi_flag_o(rssi_flag), .irq_o(irq));

  rmt_radio_model i_rmt_radio_model (.clk_sys_i(clk_sys_i), .rx_ready_i(rx_ready), .level_i(level),
    .pre_dly_i(pre_dly), .sync_dly_i(sync_dly), .signal_strength_value_o(strength),
    .preamble_seen_flag_o(pre_flag), .sync_word_flag_o(sync_flag));

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Cycle count within a tolerance
  task automatic near(input int seen, input int exp, input int tol);
    chk(32'(seen >= exp - tol && seen <= exp + tol), 32'h1);
  endtask

  // AXI4-Lite write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge clk_sys_i);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clk_sys_i);
      if (!aw_ok && awready) begin
        aw_ok = 1;
        awvalid <= 0;
      end
      if (!w_ok && wready) begin
        w_ok = 1;
        wvalid <= 0;
      end
    end while (!bvalid);
    bready <= 0;
    chk(32'(bresp), 32'(er));
  endtask

  // AXI4-Lite read into rd and rsp
  task automatic rdr(input logic [7:0] a);
    bit ar_ok;
    ar_ok = 0;
    @(posedge clk_sys_i);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge clk_sys_i);
      if (!ar_ok && arready) begin
        ar_ok = 1;
        arvalid <= 0;
      end
    end while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 0;
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return irq;
      1: return mode_ready;
      2: return rx_ready;
      3: return rssi_valid;
      4: return !vco_cal;
      default: return vco_cal;
    endcase
  endfunction

  // Count edges until the chosen signal is high
  task automatic wait_for(input int s, input int lim);
    n = 0;
    while (pick(s) !== 1'b1 && n < lim) begin
      @(posedge clk_sys_i);
      n++;
    end
  endtask

  // Set a mode and wait for its wake sequence; sleep never reports ready
  task automatic go(input logic [3:0] m);
    wr(A_MODE, 32'(m), RESP_OKAY);
    repeat (3) @(posedge clk_sys_i);
    if (m[2:0] != MODE_SLEEP) begin
      wait_for(1, 5000);
      chk(32'(mode_ready), 32'h1);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (90000) @(posedge clk_sys_i);
    errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    stop_test;
  end

  // Main sequence
  initial begin
    void'($urandom(32'hbb7f));
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 0;
    rdr(A_MODE);
    chk(rd, RST_MODE);
    rdr(A_BITRATE);
    chk(rd, RST_BITRATE);
    rdr(A_RAMP);
    chk(rd, RST_RAMP);
    rdr(8'h40);
    chk(32'(rsp), 32'(RESP_SLVERR));
    wr(8'h40, 32'h1, RESP_SLVERR);
    $display("test registers done");
    for (int m = 0; m < 6; m++) begin
      go(4'(m));
      rdr(A_STAT);
      chk(rd & 32'h7, 32'(m));
      chk(32'({xtal, synth, rx_off, tx_en, rx_en}), 32'({m != 0, m >= 2, m >= 4, m == 3, m == 5}));
    end
    $display("test modes done");
    br = 2 + $urandom % 8;
    ramp = $urandom % 64;
    wr(A_BITRATE, 32'(br), RESP_OKAY);
    wr(A_RAMP, 32'(ramp), RESP_OKAY);
    for (int ook = 0; ook < 2; ook++) begin
      go(MODE_STDBY);
      wr(A_MODE, 32'(ook * 8 + 3), RESP_OKAY);
      wait_for(5, 100);
      chk(32'(tx_en), 32'h0);
      wait_for(4, 3000);
      near(n, SYN_CYC, 3);
      wait_for(1, 3000);
      near(n, TX_FIXED_CYC + br / 2 + (ook ? 0 : ramp * RAMP_NUM / RAMP_DEN), 3);
      chk(32'({tx_en, synth, rx_en}), 32'h6);
    end
    $display("test transmit startup done");
    go(MODE_SYNTH_TO_RECEIVE);
    level <= 8'h80;
    wr(A_RXCFG, 32'h0040_0000 | 32'h1 << SMOOTH_LSB | 32'd20 << CORRECTION_BANDWIDTH_LSB | 32'h1 << AFC_BIT, RESP_OKAY);
    wr(A_MODE, 32'(MODE_RX), RESP_OKAY);
    wait_for(2, 5000);
    near(n, 63, 3);
    wait_for(3, 500);
    near(n, 14, 2);
    chk(32'(rssi_flag), 32'h1);
    go(MODE_SYNTH_TO_RECEIVE);
    wr(A_RXCFG, 32'h0, RESP_OKAY);
    wr(A_MODE, 32'(MODE_RX), RESP_OKAY);
    wait_for(2, 5000);
    near(n, 2330, 3);
    $display("test receive startup done");
    wr(A_MASK, 32'h1, RESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      go(MODE_STDBY);
      wr(A_IRQ, 32'h7, RESP_OKAY);
      br = 1 + $urandom % 4;
      to = 1 + $urandom % 3;
      e = 16 * to * br * emul[i];
      wr(A_BITRATE, 32'(br), RESP_OKAY);
      wr(A_TOUT, 32'(to * tmul[i]), RESP_OKAY);
      wr(A_RXCFG, 32'(trg[i]), RESP_OKAY);
      wr(A_MODE, 32'(MODE_RX), RESP_OKAY);
      wait_for(0, e + 40);
      if (trg[i] != 0 && i != 4)
        near(n, e, 3);
      else
        chk(32'(irq), 32'h0);
    end
    $display("test timeout triggers done");
    go(MODE_STDBY);
    wr(A_IRQ, 32'h7, RESP_OKAY);
    wr(A_MASK, 32'h0, RESP_OKAY);
    wr(A_BITRATE, 32'h1, RESP_OKAY);
    wr(A_TOUT, 32'h1, RESP_OKAY);
    wr(A_RXCFG, 32'(TRIG_RSSI), RESP_OKAY);
    wr(A_MODE, 32'(MODE_RX), RESP_OKAY);
    repeat (40) @(posedge clk_sys_i);
    rdr(A_IRQ);
    chk(rd & 32'h1, 32'h1);
    chk(32'(irq), 32'h0);
    wr(A_MASK, 32'h1, RESP_OKAY);
    chk(32'(irq), 32'h1);
    wr(A_IRQ, 32'h1, RESP_OKAY);
    repeat (2) @(posedge clk_sys_i);
    chk(32'(irq), 32'h0);
    $display("test interrupt mask done");
    pre_dly <= 16'd20;
    sync_dly <= 16'd30;
    for (int i = 2; i < 4; i++) begin
      go(MODE_STDBY);
      wr(A_IRQ, 32'h7, RESP_OKAY);
      wr(A_BITRATE, 32'd200, RESP_OKAY);
      wr(A_TOUT, 32'h010101, RESP_OKAY);
      wr(A_RXCFG, 32'h0040_0000 | 32'd20 << CORRECTION_BANDWIDTH_LSB | 32'h1 << AFC_BIT | 32'(trg[i]), RESP_OKAY);
      wr(A_MODE, 32'(MODE_RX), RESP_OKAY);
      wait_for(0, 3300);
      chk(32'(irq), 32'h0);
    end
    $display("test flags in time done");
    stop_test;
  end
endmodule
